// *** ccu_pkg.sv ***
// package with register map, mode codes and field layout of the channel pair
package ccu_pkg;
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_LOW1 = 3'h1;
  localparam logic [2:0] ADDR_HIGH1 = 3'h2;
  localparam logic [2:0] ADDR_CTRL2 = 3'h3;
  localparam logic [2:0] ADDR_LOW2 = 3'h4;
  localparam logic [2:0] ADDR_HIGH2 = 3'h5;
  localparam logic [2:0] ADDR_CFG = 3'h6;
  localparam logic [2:0] ADDR_STAT = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] VALUE_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h04;
  localparam int CFG_TSEL_LO = 0;
  localparam int CFG_TSEL_HI = 1;
  localparam int CFG_ROUTE = 2;
  localparam int STAT_FLAG1 = 0;
  localparam int STAT_FLAG2 = 1;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_SET_HIGH = 4'h8;
  localparam logic [3:0] MODE_SET_LOW = 4'h9;
  localparam logic [3:0] MODE_SOFT_INT = 4'hA;
  localparam logic [3:0] MODE_SPECIAL = 4'hB;
  localparam logic [3:0] PRESC_4 = 4'h3;
  localparam logic [3:0] PRESC_16 = 4'hF;
  typedef struct packed {
    logic [1:0] duty_low_bits;
    logic [3:0] channel_mode_field;
  } ccu_ctrl_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccu_bus_t;
endpackage

// *** ccu_unit.sv ***
// two capture/compare/pwm channels with register port and pin logic
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - mode 0000 disables the channel and resets its internal state
// - modes 0100-0111 capture on fall, rise, fourth rise, sixteenth rise
// - mode 0010 toggles output on match and sets the flag
// - mode 1000 starts output low, forces high on match, sets flag
// - mode 1001 starts output high, forces low on match, sets flag
// - mode 1010 only sets the flag; pin shows the port latch
// - mode 1011 flags, pulses timer reset, channel two starts conversion
// - modes 11xx are pwm; duty is value low byte plus control bits 5:4
// - control bits 7 and 6 always read zero
// - value low, value high and control are readable and writable
// - capture/compare use timer one or three, pwm uses timer two
// - both channels run at once and may share one timer
// - both pwm channels update duty on the timer-two period event
// - a capture copies the full sixteen bit timer count
// - a capture sets the flag; only software clears it
// - a new capture overwrites the previous value
// - edge detector watches the pin level even when it is an output
// - prescaler clears when channel off, capture left, or reset
// - changing prescaler setting directly keeps the prescaler count
// - route bit puts channel two on port c pin one or port b pin three
// - timebase select bits choose timer one or three per channel
// - compare modes match value against the assigned timer count
// - a timer write beats a special event reset
module ccu_unit
  import ccu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] timer_one_count_i,
  input wire logic [15:0] timer_three_count_i,
  input wire logic [7:0] timer_two_count_i,
  input wire logic [1:0] timer_two_prescale_i,
  input wire logic timer_two_period_i,
  input wire logic timer_one_write_i,
  input wire logic timer_three_write_i,
  input wire logic channel_pin1_i,
  input wire logic port_c_pin_one_i,
  input wire logic port_b_pin_three_i,
  input wire logic port_latch1_i,
  input wire logic port_latch2_i,
  input wire logic [1:0] pin_direction_bits_i,
  output logic channel_pin1_o,
  output logic channel_pin1_oe_b_o,
  output logic port_c_pin_one_o,
  output logic port_c_pin_one_oe_b_o,
  output logic port_b_pin_three_o,
  output logic port_b_pin_three_oe_b_o,
  output logic [1:0] channel_event_flag_o,
  output logic timer_one_reset_o,
  output logic timer_three_reset_o,
  output logic conversion_start_o
);
  ccu_bus_t bus;
  ccu_ctrl_t ctrl_reg [2];
  logic [7:0] low_reg [2];
  logic [7:0] high_reg [2];
  logic [7:0] cfg_reg;
  logic [1:0] flag_reg;
  logic [1:0] sync1_reg, sync2_reg, prev_reg;
  logic [3:0] presc_reg [2];
  logic [1:0] latch_reg;
  logic [1:0] match_prev_reg;
  logic [9:0] duty_reg [2];
  logic [1:0] pwm_reg;
  logic [1:0] spec_reg;
  logic [1:0] pin_in;
  logic [1:0] rise, fall, cap_ev, match;
  logic [15:0] tbase [2];
  logic [1:0] wr_ctrl;
  logic [1:0] ch_pin_out;
  logic [9:0] pwm_count;

  assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i,
                 rd: reg_rd_i};

  function automatic logic is_capture(input logic [3:0] m);
    is_capture = (m[3:2] == 2'b01);
  endfunction

  function automatic logic is_compare(input logic [3:0] m);
    is_compare = (m == MODE_TOGGLE) || (m[3:2] == 2'b10);
  endfunction

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'b11);
  endfunction

  assign pin_in[0] = channel_pin1_i;
  assign pin_in[1] = cfg_reg[CFG_ROUTE] ? port_c_pin_one_i
                                        : port_b_pin_three_i;

  // timebase select, timer one or three for capture/compare
  // each channel keeps its own time base, both may share one timer
  assign tbase[0] = cfg_reg[CFG_TSEL_HI] ? timer_three_count_i
                                         : timer_one_count_i;
  assign tbase[1] = (cfg_reg[CFG_TSEL_HI] | cfg_reg[CFG_TSEL_LO]) ?
                    timer_three_count_i : timer_one_count_i;

  // two stage pin synchroniser; pin level seen in any direction
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign wr_ctrl[0] = bus.wr && (bus.addr == ADDR_CTRL1);
  assign wr_ctrl[1] = bus.wr && (bus.addr == ADDR_CTRL2);
  // pwm counter: timer two count extended by its prescaler phase
  assign pwm_count = {timer_two_count_i, timer_two_prescale_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : ch
      logic [3:0] m;
      assign m = ctrl_reg[g].channel_mode_field;
      always_comb begin
        cap_ev[g] = 1'b0;
        case (m)
          MODE_CAP_FALL: cap_ev[g] = fall[g];
          MODE_CAP_RISE: cap_ev[g] = rise[g];
          MODE_CAP_RISE4: cap_ev[g] = rise[g] && (presc_reg[g] == PRESC_4);
          MODE_CAP_RISE16: cap_ev[g] = rise[g] &&
                                       (presc_reg[g] == PRESC_16);
          default: cap_ev[g] = 1'b0;
        endcase
      end
      // continuous compare; event only on the first matching cycle
      assign match[g] = is_compare(m) &&
                        ({high_reg[g], low_reg[g]} == tbase[g]) &&
                        !match_prev_reg[g];

      // prescaler cleared when off or not capturing
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || !is_capture(m)) begin
          presc_reg[g] <= 4'h0;
        end else if (rise[g] && m[1]) begin
          // count kept across direct prescaler changes
          presc_reg[g] <= (cap_ev[g]) ? 4'h0 : presc_reg[g] + 4'h1;
        end
      end

      // compare match edge memory
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          match_prev_reg[g] <= 1'b0;
        end else begin
          match_prev_reg[g] <= is_compare(m) &&
                               ({high_reg[g], low_reg[g]} == tbase[g]);
        end
      end

      // compare output latch
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          latch_reg[g] <= 1'b0;
        end else if (wr_ctrl[g]) begin
          // off forces latch low; initial level on entry
          case (bus.wdata[3:0])
            MODE_SET_HIGH: latch_reg[g] <= 1'b0;
            MODE_SET_LOW: latch_reg[g] <= 1'b1;
            MODE_OFF: latch_reg[g] <= 1'b0;
            default: latch_reg[g] <= latch_reg[g];
          endcase
        end else if (match[g]) begin
          case (m)
            MODE_TOGGLE: latch_reg[g] <= ~latch_reg[g];
            MODE_SET_HIGH: latch_reg[g] <= 1'b1;
            MODE_SET_LOW: latch_reg[g] <= 1'b0;
            default: latch_reg[g] <= latch_reg[g];
          endcase
        end
      end

      // duty reloaded on the shared timer-two period event
      always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          duty_reg[g] <= 10'h000;
          pwm_reg[g] <= 1'b0;
        end else if (!is_pwm(m)) begin
          pwm_reg[g] <= 1'b0;
        end else if (timer_two_period_i) begin
          // ten bit duty from low byte and control bits 5:4
          duty_reg[g] <= {low_reg[g], ctrl_reg[g].duty_low_bits};
          pwm_reg[g] <= ({low_reg[g], ctrl_reg[g].duty_low_bits} != 10'h000);
        end else if (pwm_count == duty_reg[g]) begin
          pwm_reg[g] <= 1'b0;
        end
      end

      // soft interrupt mode leaves the pin to the port latch
      always_comb begin
        if (is_pwm(m)) begin
          ch_pin_out[g] = pwm_reg[g];
        end else if (is_compare(m) && m != MODE_SOFT_INT) begin
          ch_pin_out[g] = latch_reg[g];
        end else begin
          ch_pin_out[g] = (g == 0) ? port_latch1_i : port_latch2_i;
        end
      end
    end
  endgenerate

  // special event pulse, one cycle per match
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      spec_reg <= 2'h0;
    end else begin
      spec_reg[0] <= match[0] &&
                     (ctrl_reg[0].channel_mode_field == MODE_SPECIAL);
      spec_reg[1] <= match[1] &&
                     (ctrl_reg[1].channel_mode_field == MODE_SPECIAL);
    end
  end

  // a timer write takes precedence over the special event reset
  assign timer_one_reset_o = !timer_one_write_i &&
    ((spec_reg[0] && !cfg_reg[CFG_TSEL_HI]) ||
     (spec_reg[1] && !(cfg_reg[CFG_TSEL_HI] | cfg_reg[CFG_TSEL_LO])));
  assign timer_three_reset_o = !timer_three_write_i &&
    ((spec_reg[0] && cfg_reg[CFG_TSEL_HI]) ||
     (spec_reg[1] && (cfg_reg[CFG_TSEL_HI] | cfg_reg[CFG_TSEL_LO])));
  assign conversion_start_o = spec_reg[1];

  // pin drivers; enable low while driving
  assign channel_pin1_o = ch_pin_out[0];
  assign channel_pin1_oe_b_o = pin_direction_bits_i[0];
  assign port_c_pin_one_o = ch_pin_out[1];
  assign port_c_pin_one_oe_b_o = cfg_reg[CFG_ROUTE] ?
                                 pin_direction_bits_i[1] : 1'b1;
  assign port_b_pin_three_o = ch_pin_out[1];
  assign port_b_pin_three_oe_b_o = cfg_reg[CFG_ROUTE] ?
                                   1'b1 : pin_direction_bits_i[1];

  // control and config registers; mode 0000 is a plain off
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctrl_reg[0] <= CTRL_RESET[5:0];
      ctrl_reg[1] <= CTRL_RESET[5:0];
      cfg_reg <= CFG_RESET;
    end else begin
      if (wr_ctrl[0]) ctrl_reg[0] <= bus.wdata[5:0];
      if (wr_ctrl[1]) ctrl_reg[1] <= bus.wdata[5:0];
      if (bus.wr && bus.addr == ADDR_CFG) cfg_reg <= bus.wdata & 8'h07;
    end
  end

  // capture copies the timer; newer capture overwrites
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      low_reg[0] <= VALUE_RESET;
      low_reg[1] <= VALUE_RESET;
      high_reg[0] <= VALUE_RESET;
      high_reg[1] <= VALUE_RESET;
    end else begin
      if (cap_ev[0]) begin
        {high_reg[0], low_reg[0]} <= tbase[0];
      end else begin
        if (bus.wr && bus.addr == ADDR_LOW1) low_reg[0] <= bus.wdata;
        if (bus.wr && bus.addr == ADDR_HIGH1) high_reg[0] <= bus.wdata;
      end
      if (cap_ev[1]) begin
        {high_reg[1], low_reg[1]} <= tbase[1];
      end else begin
        if (bus.wr && bus.addr == ADDR_LOW2) low_reg[1] <= bus.wdata;
        if (bus.wr && bus.addr == ADDR_HIGH2) high_reg[1] <= bus.wdata;
      end
    end
  end

  // flag set by capture or match; set wins over software clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      flag_reg <= 2'h0;
    end else begin
      flag_reg <= ((bus.wr && bus.addr == ADDR_STAT) ?
                   (flag_reg & ~bus.wdata[1:0]) : flag_reg) |
                  cap_ev | match;
    end
  end
  assign channel_event_flag_o = flag_reg;

  // read mux, control bits 7:6 read zero; unmapped never occurs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_CTRL1: reg_rdata_o <= {2'b00, ctrl_reg[0]} & CTRL_MASK;
        ADDR_LOW1: reg_rdata_o <= low_reg[0];
        ADDR_HIGH1: reg_rdata_o <= high_reg[0];
        ADDR_CTRL2: reg_rdata_o <= {2'b00, ctrl_reg[1]} & CTRL_MASK;
        ADDR_LOW2: reg_rdata_o <= low_reg[1];
        ADDR_HIGH2: reg_rdata_o <= high_reg[1];
        ADDR_CFG: reg_rdata_o <= cfg_reg;
        ADDR_STAT: reg_rdata_o <= {6'h00, flag_reg};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // control one read never shows bits 7:6
  a_ctrl_top_zero: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $past(bus.rd) && $past(bus.addr) == ADDR_CTRL1
    |-> reg_rdata_o[7:6] == 2'b00)
    else $error("control bits 7:6 read nonzero");
  a_capture_load: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    cap_ev[0] |=> {high_reg[0], low_reg[0]} == $past(tbase[0]))
    else $error("capture did not load timer");
  a_capture_flag: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    cap_ev[1] |=> flag_reg[1])
    else $error("capture flag not set");
  // flag holds until software clears it
  a_flag_sticky: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    flag_reg[0] && !(bus.wr && bus.addr == ADDR_STAT && bus.wdata[0])
    |=> flag_reg[0])
    else $error("flag cleared without software");
  a_presc_clear: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    !is_capture(ctrl_reg[0].channel_mode_field)
    |=> presc_reg[0] == 4'h0)
    else $error("prescaler kept count outside capture");
  a_toggle_match: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    match[0] && ctrl_reg[0].channel_mode_field == MODE_TOGGLE
    && !wr_ctrl[0] |=> latch_reg[0] != $past(latch_reg[0]))
    else $error("toggle missed");
  a_off_latch: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_ctrl[1] && bus.wdata[3:0] == MODE_OFF
    |=> latch_reg[1] == 1'b0)
    else $error("latch not low after off");
  // special event follows match and starts conversion
  a_special_pulse: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    match[1] && ctrl_reg[1].channel_mode_field == MODE_SPECIAL
    |=> conversion_start_o ##1 !conversion_start_o)
    else $error("special event pulse wrong");
  a_write_wins: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    timer_one_write_i |-> !timer_one_reset_o)
    else $error("reset applied over timer write");
  c_capture: cover property (@(posedge sys_clk_i) cap_ev[0]);
  c_match: cover property (@(posedge sys_clk_i) match[0]);
  c_special: cover property (@(posedge sys_clk_i) spec_reg[0]);
  c_pwm_high: cover property (@(posedge sys_clk_i) pwm_reg[1]);
endmodule

// *** ccu_pin_model.sv ***
// far-side pin model: resolves one channel pin from both drivers
`timescale 1ns/1ps
module ccu_pin_model (
  input wire logic drv_i,
  input wire logic oe_b_i,
  input wire logic ext_i,
  output logic pin_o
);
  // own drive seen
  // while the device drives, the wire follows it; else the outside level
  assign pin_o = oe_b_i ? ext_i : drv_i;
endmodule

// *** ccu_unit_test.sv ***
// self-checking bench for the capture/compare/pwm channel pair
`timescale 1ns/1ps
module ccu_unit_test;
  import ccu_pkg::*;
  typedef struct {
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } ccu_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] t1 = 16'h0000;
  logic [15:0] t3 = 16'h0000;
  logic [15:0] x1;
  logic [15:0] x2;
  logic [7:0] t2 = 8'h00;
  logic [1:0] t2p = 2'h0;
  logic [1:0] dir = 2'h3;
  logic [1:0] flag;
  logic per = 1'b0;
  logic t3w = 1'b0;
  logic t1w = 1'b0;
  logic e1 = 1'b0;
  logic e2 = 1'b0;
  logic lat1 = 1'b0;
  logic p1, pc, pb, o1, oe1, oc, oec, ob, oeb, r1, r3, cs;
  int fail_count = 0;
  int n_checks = 0;
  int n1 = 0;
  int n3 = 0;
  int nc = 0;
  ccu_row_t rows [6] = '{
    '{ADDR_CTRL1, 8'hFF, 8'h3F}, '{ADDR_LOW1, 8'hA5, 8'hA5},
    '{ADDR_HIGH1, 8'h5A, 8'h5A}, '{ADDR_CTRL2, 8'hD7, 8'h17},
    '{ADDR_LOW2, 8'h3C, 8'h3C}, '{ADDR_HIGH2, 8'hC3, 8'hC3}};
  logic [7:0] rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h04, 8'h00};
  // clock at 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  ccu_unit ccu_unit_i (.sys_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .timer_one_count_i(t1), .timer_three_count_i(t3),
    .timer_two_count_i(t2), .timer_two_prescale_i(t2p),
    .timer_two_period_i(per), .timer_one_write_i(t1w),
    .timer_three_write_i(t3w), .channel_pin1_i(p1), .port_c_pin_one_i(pc),
    .port_b_pin_three_i(pb), .port_latch1_i(lat1), .port_latch2_i(1'b0),
    .pin_direction_bits_i(dir), .channel_pin1_o(o1),
    .channel_pin1_oe_b_o(oe1), .port_c_pin_one_o(oc),
    .port_c_pin_one_oe_b_o(oec), .port_b_pin_three_o(ob),
    .port_b_pin_three_oe_b_o(oeb), .channel_event_flag_o(flag),
    .timer_one_reset_o(r1), .timer_three_reset_o(r3),
    .conversion_start_o(cs));
  // far-side pins
  ccu_pin_model ccu_pin_model_i (.drv_i(o1), .oe_b_i(oe1), .ext_i(e1),
    .pin_o(p1));
  ccu_pin_model ccu_pin_model_c_i (.drv_i(oc), .oe_b_i(oec), .ext_i(e2),
    .pin_o(pc));
  ccu_pin_model ccu_pin_model_b_i (.drv_i(ob), .oe_b_i(oeb), .ext_i(e2),
    .pin_o(pb));
  // count the one-cycle trigger pulses
  always @(posedge clk) begin
    if (r1 === 1'b1) n1++;
    if (r3 === 1'b1) n3++;
    if (cs === 1'b1) nc++;
  end
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task md(input logic [2:0] a, input logic [3:0] m);
    wr(a, {4'h0, m});
    wr(ADDR_STAT, 8'h03);
  endtask
  task pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      e1 <= 1'b1;
      e2 <= 1'b1;
      repeat (8) @(posedge clk);
      e1 <= 1'b0;
      e2 <= 1'b0;
      repeat (8) @(posedge clk);
    end
    #1;
  endtask
  task hit(input logic [15:0] v);
    @(posedge clk);
    t1 <= v;
    t3 <= v;
    repeat (4) @(posedge clk);
    t1 <= ~v;
    t3 <= ~v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #(100 * 20000);
    fail_count++;
    end_of_test;
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), rst_v[i]);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("test registers done");
    md(ADDR_CTRL1, MODE_CAP_RISE);
    md(ADDR_CTRL2, MODE_CAP_RISE);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CFG, 8'h04 | 8'(i));
      wr(ADDR_STAT, 8'h03);
      t1 <= 16'h1100 + 16'(i);
      t3 <= 16'h3300 + 16'(i);
      pulses(1);
      x1 = (i > 1) ? t3 : t1;
      x2 = (i > 0) ? t3 : t1;
      rd(ADDR_LOW1, x1[7:0]);
      rd(ADDR_HIGH1, x1[15:8]);
      rd(ADDR_LOW2, x2[7:0]);
      rd(ADDR_HIGH2, x2[15:8]);
    end
    repeat (30) @(posedge clk);
    chk({6'h00, flag}, 8'h03);
    wr(ADDR_STAT, 8'h01);
    #1;
    chk({6'h00, flag}, 8'h02);
    wr(ADDR_CFG, 8'h04);
    t1 <= 16'h2222;
    pulses(1);
    t1 <= 16'h4444;
    pulses(1);
    rd(ADDR_LOW1, 8'h44);
    rd(ADDR_HIGH1, 8'h44);
    $display("test capture done");
    // channel two off so that only channel one raises flags
    md(ADDR_CTRL2, MODE_OFF);
    md(ADDR_CTRL1, MODE_CAP_FALL);
    e1 <= 1'b1;
    repeat (10) @(posedge clk);
    chk({6'h00, flag}, 8'h00);
    e1 <= 1'b0;
    repeat (10) @(posedge clk);
    chk({6'h00, flag}, 8'h01);
    md(ADDR_CTRL1, MODE_CAP_RISE4);
    pulses(2);
    md(ADDR_CTRL1, MODE_OFF);
    md(ADDR_CTRL1, MODE_CAP_RISE4);
    pulses(3);
    chk({6'h00, flag}, 8'h00);
    pulses(1);
    chk({6'h00, flag}, 8'h01);
    md(ADDR_CTRL1, MODE_OFF);
    md(ADDR_CTRL1, MODE_CAP_RISE16);
    pulses(15);
    chk({6'h00, flag}, 8'h00);
    pulses(1);
    chk({6'h00, flag}, 8'h01);
    $display("test prescaler done");
    dir <= 2'h0;
    wr(ADDR_LOW1, 8'h40);
    wr(ADDR_HIGH1, 8'h00);
    md(ADDR_CTRL1, MODE_SET_HIGH);
    chk({7'h00, o1}, 8'h00);
    hit(16'h0040);
    chk({4'h0, flag, o1, oe1}, 8'h06);
    md(ADDR_CTRL1, MODE_SET_LOW);
    chk({7'h00, o1}, 8'h01);
    hit(16'h0040);
    chk({5'h00, flag, o1}, 8'h02);
    md(ADDR_CTRL1, MODE_TOGGLE);
    hit(16'h0040);
    chk({5'h00, flag, o1}, 8'h03);
    hit(16'h0040);
    chk({7'h00, o1}, 8'h00);
    lat1 <= 1'b1;
    md(ADDR_CTRL1, MODE_SOFT_INT);
    hit(16'h0040);
    chk({5'h00, flag, o1}, 8'h03);
    md(ADDR_CTRL1, MODE_SET_LOW);
    md(ADDR_CTRL1, MODE_OFF);
    md(ADDR_CTRL1, MODE_TOGGLE);
    hit(16'h0040);
    chk({7'h00, o1}, 8'h01);
    $display("test compare done");
    wr(ADDR_LOW2, 8'h40);
    wr(ADDR_HIGH2, 8'h00);
    wr(ADDR_CFG, 8'h05);
    md(ADDR_CTRL1, MODE_OFF);
    md(ADDR_CTRL2, MODE_SPECIAL);
    hit(16'h0040);
    chk({5'h00, flag, 1'b0}, 8'h04);
    chk(8'(n3 * 16 + nc), 8'h11);
    // the timer write blocks the reset, the conversion still starts
    t3w <= 1'b1;
    hit(16'h0040);
    t3w <= 1'b0;
    chk(8'(n3), 8'h01);
    md(ADDR_CTRL2, MODE_OFF);
    md(ADDR_CTRL1, MODE_SPECIAL);
    hit(16'h0040);
    chk(8'(n1 * 16 + nc), 8'h12);
    t1w <= 1'b1;
    hit(16'h0040);
    t1w <= 1'b0;
    chk(8'(n1), 8'h01);
    md(ADDR_CTRL2, MODE_SET_LOW);
    chk({6'h00, oc, ob}, 8'h03);
    chk({6'h00, oec, oeb}, 8'h01);
    wr(ADDR_CFG, 8'h00);
    #1;
    chk({6'h00, oec, oeb}, 8'h02);
    $display("test special done");
    wr(ADDR_LOW1, 8'h02);
    wr(ADDR_CTRL1, 8'h1C);
    @(posedge clk);
    per <= 1'b1;
    @(posedge clk);
    per <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h00, o1}, 8'h01);
    t2 <= 8'h02;
    t2p <= 2'h1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, o1}, 8'h00);
    $display("test pwm done");
    // mid-run reset with a part-counted prescaler
    dir <= 2'h3;
    md(ADDR_CTRL1, MODE_CAP_RISE4);
    pulses(2);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_CTRL1, 8'h00);
    rd(ADDR_CFG, 8'h04);
    md(ADDR_CTRL1, MODE_CAP_RISE4);
    pulses(3);
    chk({6'h00, flag}, 8'h00);
    pulses(1);
    chk({6'h00, flag}, 8'h01);
    $display("test reset done");
    end_of_test;
  end
endmodule
